// *** hw/encoder_line_map.vh ***
/*
 * register map, field positions, reset values, encoder type codes and timing
 * constants shared by the encoder turns and line setup block.
 * assumes a 10 MHz pclk and an 8-bit APB byte address.
 */
`ifndef ENCODER_LINE_MAP_VH
`define ENCODER_LINE_MAP_VH

// register byte offsets
`define ADDR_CTRL        8'h00
`define ADDR_TURNS       8'h04
`define ADDR_LINES       8'h08
`define ADDR_POLES       8'h0c
`define ADDR_PITCH       8'h10
`define ADDR_STATUS      8'h14
`define ADDR_IRQ_STATUS  8'h18
`define ADDR_IRQ_MASK    8'h1c
`define ADDR_TURNS_DISP  8'h20
`define ADDR_LINES_APPL  8'h24
`define ADDR_REV_LENGTH  8'h28

// control register fields
`define CTRL_DRIVE_EN    0
`define CTRL_AUTOCFG_EN  1
`define CTRL_SERVO_MODE  2
`define CTRL_LINROT_LSB  3
`define CTRL_LINROT_MSB  4
`define CTRL_TYPE_LSB    8
`define CTRL_TYPE_MSB    11
`define CTRL_SWF_LSB     12
`define CTRL_SWF_MSB     15
`define CTRL_INTERP_LSB  16
`define CTRL_INTERP_MSB  19
`define CTRL_MAP_SEL     20
`define CTRL_W           21
`define CTRL_RESET       21'h0a0008

// interrupt bits
`define IRQ_TRIP         0
`define IRQ_AUTOCFG      1
`define IRQ_REINIT       2
`define IRQ_W            3

// status fields
`define ST_OVERSIZE      0
`define ST_COMM_ONLY     1
`define ST_RATE_CUT      2
`define ST_POW2          3
`define ST_RES_LSB       8
`define ST_RES_MSB       12

// widths, limits and reset values
`define LINES_W          19
`define LINES_MAX        32'h0007a120
`define LINES_RESET      19'h00400
`define LINES_RESET_LOG2 5'h0a
`define LINES_POW2_MIN   19'h00002
`define LINES_POW2_MAX   19'h08000
`define TURNS_RESET      8'h10
`define TURNS_BITS_MAX   5'h10
`define RATIO_SHOWN_MAX  16'h00ff
`define INTERP_MAX       4'hb
`define POLES_RESET      16'h0606
`define PITCH_RESET      16'h0020

// encoder types
`define T_QUAD           4'h0
`define T_FREQ_DIR       4'h1
`define T_FWD_REV        4'h2
`define T_QUAD_COMM      4'h3
`define T_FREQ_DIR_COMM  4'h4
`define T_FWD_REV_COMM   4'h5
`define T_SINE_COS       4'h6
`define T_SC_ASYNC       4'h7
`define T_SC_BIDIR       4'h8
`define T_SC_SYNC        4'h9
`define T_BIDIR_ONLY     4'ha
`define T_SYNC_ONLY      4'hb

// switching frequency codes
`define SWF_6K           4'h2
`define SWF_12K          4'h4

// background sampling
`define CLK_PERIOD_NS    100
`define BG_PERIOD_NS     250000

`endif

// *** hw/encoder_line_setup.v ***
/*
 * encoder turns masking, linear comms-to-sine ratio with hidden oversize value,
 * lines-per-revolution setting with background apply, re-initialisation trip,
 * commutation-only detection and current-loop sample-rate reduction.
 * APB slave, zero wait states. encoder and auto-configuration inputs come from
 * logic on pclk and are not synchronised.
 */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "encoder_line_map.vh"

module encoder_line_setup (
  // apb
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output wire                pready,
  output wire                pslverr,
  output reg  [31:0]         prdata,
  // encoder side
  input  wire [15:0]         raw_turns,
  input  wire                encoder_init,
  output reg                 autoconfig_request,
  input  wire                autoconfig_done,
  input  wire [15:0]         autoconfig_ratio,
  input  wire [7:0]          autoconfig_turns,
  input  wire [`LINES_W-1:0] autoconfig_lines,
  // results
  output reg  [15:0]         turns_count_display,
  output reg  [15:0]         comms_sine_ratio,
  output reg  [`LINES_W-1:0] equivalent_lines_per_rev,
  output reg                 commutation_only,
  output reg                 sample_rate_reduced,
  output reg  [4:0]          total_res_bits,
  output reg  [23:0]         rev_length,
  output reg                 encoder_reinit,
  output wire                irq
);

  localparam integer BG_CYCLES = (`BG_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  // sized copies: a literal cannot be sliced, a parameter can
  localparam [31:0] LINES_MAX_P = `LINES_MAX;
  localparam [15:0] RATIO_MAX_P = `RATIO_SHOWN_MAX;
  localparam [15:0] POLES_RST_P = `POLES_RESET;

  // software registers
  reg  [`CTRL_W-1:0]  ctrl;
  reg  [7:0]          turns_bits_setting;
  reg  [`LINES_W-1:0] lines_per_rev_setting;
  reg  [4:0]          setting_log2;
  reg                 setting_pow2;
  reg  [15:0]         poles;
  reg  [15:0]         pole_pitch;
  reg  [`IRQ_W-1:0]   irq_status;
  reg  [`IRQ_W-1:0]   irq_mask;
  // internal state
  reg  [15:0]         hidden_ratio;
  reg                 oversize_held;
  reg                 autoconfig_pending;
  reg  [4:0]          applied_log2;
  reg                 applied_pow2;
  reg  [7:0]          poles_seen;
  reg  [11:0]         bg_count;
  reg                 bg_tick;
  reg  [31:0]         next_rdata;
  reg                 mapped;

  wire [3:0] enc_type   = ctrl[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];
  wire [1:0] lin_rot    = ctrl[`CTRL_LINROT_MSB:`CTRL_LINROT_LSB];
  wire       rotary     = (lin_rot != 2'h0);
  wire       drive_en   = ctrl[`CTRL_DRIVE_EN];
  wire [3:0] interp     = ctrl[`CTRL_INTERP_MSB:`CTRL_INTERP_LSB];
  wire [3:0] swf        = ctrl[`CTRL_SWF_MSB:`CTRL_SWF_LSB];
  wire [7:0] poles_sel  = ctrl[`CTRL_MAP_SEL] ? poles[15:8] : poles[7:0];

  wire sc_comms   = (enc_type == `T_SC_ASYNC) || (enc_type == `T_SC_BIDIR) ||
                    (enc_type == `T_SC_SYNC);
  wire servo_inc  = (enc_type == `T_QUAD_COMM) || (enc_type == `T_FREQ_DIR_COMM) ||
                    (enc_type == `T_FWD_REV_COMM);
  wire serial_abs = (enc_type == `T_BIDIR_ONLY) || (enc_type == `T_SYNC_ONLY);
  wire comms_enc  = sc_comms || serial_abs;

  // apb access decode
  wire setup_phase = psel && !penable;
  wire access      = psel && penable;
  wire wr_access   = access && pwrite && mapped;
  wire rd_access   = access && !pwrite && mapped;
  assign pready    = 1'b1;
  assign pslverr   = access && !mapped;

  always @* begin
    case (paddr)
      `ADDR_CTRL, `ADDR_TURNS, `ADDR_LINES, `ADDR_POLES, `ADDR_PITCH,
      `ADDR_STATUS, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_TURNS_DISP,
      `ADDR_LINES_APPL, `ADDR_REV_LENGTH: mapped = 1'b1;
      default:                            mapped = 1'b0;
    endcase
  end

  // lines write path: range clamp, then shaping
  wire                wr_lines   = wr_access && (paddr == `ADDR_LINES);
  wire [`LINES_W-1:0] wr_clamped = (pwdata > `LINES_MAX) ? LINES_MAX_P[`LINES_W-1:0] :
                                   pwdata[`LINES_W-1:0];
  wire                ac_lines   = autoconfig_done && ((sc_comms && rotary) || serial_abs);
  wire [`LINES_W-1:0] ac_value   = serial_abs ? {`LINES_W{1'b0}} : autoconfig_lines;
  wire [`LINES_W-1:0] shape_in   = ac_lines ? ac_value : wr_clamped;
  wire [`LINES_W-1:0] shaped;
  wire [4:0]          shaped_log2;
  wire                shaped_pow2;

  lines_shaper u_shaper (
    .enc_type   (enc_type),
    .servo_mode (ctrl[`CTRL_SERVO_MODE]),
    .rotary     (rotary),
    .lines_in   (shape_in),
    .lines_out  (shaped),
    .lines_log2 (shaped_log2),
    .lines_pow2 (shaped_pow2)
  );

  wire lines_load = ac_lines || wr_lines;
  wire trip_evt   = wr_lines || (ac_lines && shaped != lines_per_rev_setting);
  wire ratio_ac   = autoconfig_done && sc_comms && !rotary;

  // background sampling tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bg_count <= 12'h000;
      bg_tick  <= 1'b0;
    end else if (bg_count == BG_CYCLES[11:0] - 12'h001) begin
      bg_count <= 12'h000;
      bg_tick  <= 1'b1;
    end else begin
      bg_count <= bg_count + 12'h001;
      bg_tick  <= 1'b0;
    end
  end

  // settings and auto-configuration results
  // autoconfig wins over a same-cycle apb write to the same setting
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                  <= `CTRL_RESET;
      turns_bits_setting    <= `TURNS_RESET;
      lines_per_rev_setting <= `LINES_RESET;
      setting_log2          <= `LINES_RESET_LOG2;
      setting_pow2          <= 1'b1;
      poles                 <= `POLES_RESET;
      pole_pitch            <= `PITCH_RESET;
      irq_mask              <= {`IRQ_W{1'b0}};
      hidden_ratio          <= 16'h0000;
      oversize_held         <= 1'b0;
    end else begin
      if (wr_access) begin
        case (paddr)
          `ADDR_CTRL:     ctrl       <= pwdata[`CTRL_W-1:0];
          `ADDR_POLES:    poles      <= pwdata[15:0];
          `ADDR_PITCH:    pole_pitch <= pwdata[15:0];
          `ADDR_IRQ_MASK: irq_mask   <= pwdata[`IRQ_W-1:0];
          default:        ;
        endcase
      end
      if (ratio_ac) begin
        if (autoconfig_ratio > `RATIO_SHOWN_MAX) begin
          hidden_ratio       <= autoconfig_ratio;
          oversize_held      <= 1'b1;
          turns_bits_setting <= RATIO_MAX_P[7:0];
        end else begin
          hidden_ratio       <= 16'h0000;
          oversize_held      <= 1'b0;
          turns_bits_setting <= autoconfig_ratio[7:0];
        end
      end else if (autoconfig_done && comms_enc && rotary) begin
        turns_bits_setting <= autoconfig_turns;
      end else if (wr_access && paddr == `ADDR_TURNS && !oversize_held) begin
        turns_bits_setting <= pwdata[7:0];
      end
      if (lines_load) begin
        lines_per_rev_setting <= shaped;
        setting_log2          <= shaped_log2;
        setting_pow2          <= shaped_pow2;
      end
    end
  end

  // auto-configuration requests: once after reset, then per initialisation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autoconfig_pending <= 1'b1;
      autoconfig_request <= 1'b0;
    end else begin
      autoconfig_request <= 1'b0;
      if (encoder_init)
        autoconfig_pending <= 1'b1;
      if ((autoconfig_pending || encoder_init) && ctrl[`CTRL_AUTOCFG_EN]) begin
        autoconfig_request <= 1'b1;
        autoconfig_pending <= 1'b0;
      end
    end
  end

  // applied lines value, reinitialisation
  // only the background tick, with the drive disabled, moves the setting into use, so a running
  // drive never sees its scaling change underneath it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      equivalent_lines_per_rev <= `LINES_RESET;
      applied_log2             <= `LINES_RESET_LOG2;
      applied_pow2             <= 1'b1;
      poles_seen               <= POLES_RST_P[7:0];
      encoder_reinit           <= 1'b0;
    end else begin
      encoder_reinit <= 1'b0;
      poles_seen     <= poles_sel;
      if (bg_tick && !drive_en) begin
        equivalent_lines_per_rev <= lines_per_rev_setting;
        applied_log2             <= setting_log2;
        applied_pow2             <= setting_pow2;
      end
      if (servo_inc && ((bg_tick && !drive_en &&
          lines_per_rev_setting != equivalent_lines_per_rev) || poles_sel != poles_seen))
        encoder_reinit <= 1'b1;
    end
  end

  // derived outputs, registered
  wire [4:0]  turns_n   = (turns_bits_setting > {3'h0, `TURNS_BITS_MAX}) ?
                          `TURNS_BITS_MAX : turns_bits_setting[4:0];
  wire [16:0] mask_wide = (17'h00001 << turns_n) - 17'h00001;
  wire [3:0]  interp_c  = (interp > `INTERP_MAX) ? `INTERP_MAX : interp;
  wire        rate_cut  = !rotary && !applied_pow2 &&
                          (swf == `SWF_6K || swf == `SWF_12K);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      turns_count_display <= 16'h0000;
      comms_sine_ratio    <= 16'h0000;
      commutation_only    <= 1'b0;
      sample_rate_reduced <= 1'b0;
      total_res_bits      <= 5'h00;
      rev_length          <= 24'h000000;
    end else begin
      if (!rotary && comms_enc)
        turns_count_display <= raw_turns;
      else
        turns_count_display <= raw_turns & mask_wide[15:0];
      comms_sine_ratio    <= oversize_held ? hidden_ratio :
                             {8'h00, turns_bits_setting};
      commutation_only    <= servo_inc &&
                             equivalent_lines_per_rev == {`LINES_W{1'b0}};
      sample_rate_reduced <= rate_cut;
      total_res_bits      <= applied_log2 + {1'b0, interp_c};
      rev_length          <= pole_pitch * {8'h00, poles_sel};
    end
  end

  // interrupt status: sticky, cleared by reading, set wins
  wire [`IRQ_W-1:0] irq_set;
  assign irq_set[`IRQ_TRIP]    = trip_evt;
  assign irq_set[`IRQ_AUTOCFG] = autoconfig_done;
  assign irq_set[`IRQ_REINIT]  = encoder_reinit;
  wire irq_rd = rd_access && (paddr == `ADDR_IRQ_STATUS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_status <= {`IRQ_W{1'b0}};
    else if (irq_rd)
      irq_status <= irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  assign irq = |(irq_status & irq_mask);

  // read data, captured in the setup cycle
  always @* begin
    next_rdata = 32'h00000000;
    case (paddr)
      `ADDR_CTRL:       next_rdata[`CTRL_W-1:0]   = ctrl;
      `ADDR_TURNS:      next_rdata[7:0]           = turns_bits_setting;
      `ADDR_LINES:      next_rdata[`LINES_W-1:0]  = lines_per_rev_setting;
      `ADDR_POLES:      next_rdata[15:0]          = poles;
      `ADDR_PITCH:      next_rdata[15:0]          = pole_pitch;
      `ADDR_STATUS: begin
        next_rdata[`ST_OVERSIZE]             = oversize_held;
        next_rdata[`ST_COMM_ONLY]            = commutation_only;
        next_rdata[`ST_RATE_CUT]             = sample_rate_reduced;
        next_rdata[`ST_POW2]                 = applied_pow2;
        next_rdata[`ST_RES_MSB:`ST_RES_LSB]  = total_res_bits;
      end
      `ADDR_IRQ_STATUS: next_rdata[`IRQ_W-1:0]    = irq_status;
      `ADDR_IRQ_MASK:   next_rdata[`IRQ_W-1:0]    = irq_mask;
      `ADDR_TURNS_DISP: next_rdata[15:0]          = turns_count_display;
      `ADDR_LINES_APPL: next_rdata[`LINES_W-1:0]  = equivalent_lines_per_rev;
      `ADDR_REV_LENGTH: next_rdata[23:0]          = rev_length;
      default:          next_rdata                = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup_phase && !pwrite)
      prdata <= next_rdata;
  end

endmodule // encoder_line_setup

// *** hw/lines_shaper.v ***
/*
 * combinational shaping of a lines-per-revolution value: power-of-two forcing
 * for rotary sine/cosine encoders with comms, minimum-of-one clamp except servo-mode servo incremental and serial-only types, floor log2.
 * assumes the input is already limited to the settable range.
 */
`timescale 1ns/10ps
`include "encoder_line_map.vh"

module lines_shaper (
  // selection
  input  wire [3:0]          enc_type,
  input  wire                servo_mode,
  input  wire                rotary,
  // value
  input  wire [`LINES_W-1:0] lines_in,
  output reg  [`LINES_W-1:0] lines_out,
  output wire [4:0]          lines_log2,
  output wire                lines_pow2
);

  function [4:0] floor_log2;
    input [`LINES_W-1:0] v;
    integer i;
    begin
      floor_log2 = 5'h00;
      for (i = 0; i < `LINES_W; i = i + 1) begin
        if (v[i])
          floor_log2 = i[4:0];
      end
    end
  endfunction

  wire sc_comms   = (enc_type == `T_SC_ASYNC) || (enc_type == `T_SC_BIDIR) ||
                    (enc_type == `T_SC_SYNC);
  wire servo_inc  = (enc_type == `T_QUAD_COMM) || (enc_type == `T_FREQ_DIR_COMM) ||
                    (enc_type == `T_FWD_REV_COMM);
  wire serial_abs = (enc_type == `T_BIDIR_ONLY) || (enc_type == `T_SYNC_ONLY);
  wire [4:0] in_log2 = floor_log2(lines_in);

  always @* begin
    if (sc_comms && rotary) begin
      if (lines_in < `LINES_POW2_MIN)
        lines_out = `LINES_POW2_MIN;
      else if (lines_in > `LINES_POW2_MAX)
        lines_out = `LINES_POW2_MAX;
      else
        lines_out = {{(`LINES_W-1){1'b0}}, 1'b1} << in_log2;
    end else if (lines_in == {`LINES_W{1'b0}} && !(servo_inc && servo_mode) && !serial_abs) begin
      lines_out = {{(`LINES_W-1){1'b0}}, 1'b1};
    end else begin
      lines_out = lines_in;
    end
  end

  assign lines_log2 = floor_log2(lines_out);
  assign lines_pow2 = (lines_out != {`LINES_W{1'b0}}) &&
                      ((lines_out & (lines_out - {{(`LINES_W-1){1'b0}}, 1'b1})) ==
                       {`LINES_W{1'b0}});

endmodule // lines_shaper

// *** sim/encoder_line_setup_sva.sv ***
/*
 port checker for encoder_line_setup: apb answer, pulses, derived levels.
 assumes pclk domain only, reset presetn active low.
*/
`timescale 1ns/10ps
`include "encoder_line_map.vh"
module encoder_line_setup_sva (
  // apb
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [31:0]         prdata,
  // results
  input wire logic                autoconfig_request,
  input wire logic [`LINES_W-1:0] equivalent_lines_per_rev,
  input wire logic                commutation_only,
  input wire logic                sample_rate_reduced,
  input wire logic [4:0]          total_res_bits,
  input wire logic                encoder_reinit
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire unm = (paddr > 8'h28) || (paddr[1:0] != 2'b00);
  wire [`LINES_W-1:0] lv = equivalent_lines_per_rev;
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  chk_access_ready: assert property (s_setup ##1 s_access |-> pready)
    else $error("no ready in access phase");
  chk_unmapped_err: assert property (psel && penable && unm |-> pslverr)
    else $error("unmapped access without error");
  chk_mapped_ok: assert property (psel && penable && !unm |-> !pslverr)
    else $error("mapped access flagged");
  chk_unmapped_zero: assert property (psel && penable && !pwrite && unm |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_reinit_pulse: assert property (encoder_reinit |=> !encoder_reinit)
    else $error("reinit longer than one cycle");
  chk_request_pulse: assert property (autoconfig_request |=> !autoconfig_request)
    else $error("request longer than one cycle");
  chk_comm_only: assert property (commutation_only && $stable(lv) |-> lv == 0)
    else $error("commutation only with lines");
  chk_rate_cut: assert property (sample_rate_reduced && $stable(lv) |-> lv != 0 && (lv & (lv - 1)) != 0)
    else $error("rate cut with power of two lines");
  chk_lines_max: assert property (lv <= 19'd500000)
    else $error("applied lines above limit");
  chk_res_bound: assert property (total_res_bits <= 5'd29)
    else $error("resolution above limit");
endmodule // encoder_line_setup_sva
bind encoder_line_setup encoder_line_setup_sva chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .autoconfig_request(autoconfig_request), .equivalent_lines_per_rev(equivalent_lines_per_rev),
  .commutation_only(commutation_only), .sample_rate_reduced(sample_rate_reduced),
  .total_res_bits(total_res_bits), .encoder_reinit(encoder_reinit));

// *** sim/encoder_model.sv ***
/*
 far-side encoder model: revolution counter and auto-configuration answers.
 assumes the bench sets the answer data and the answer delay.
*/
`timescale 1ns/10ps
`include "encoder_line_map.vh"
module encoder_model (
  // clock
  input  wire logic                pclk,
  input  wire logic                presetn,
  // bench settings
  input  wire logic [3:0]          cfg_delay,
  input  wire logic [15:0]         cfg_ratio,
  input  wire logic [7:0]          cfg_turns,
  input  wire logic [`LINES_W-1:0] cfg_lines,
  // device side
  input  wire logic                autoconfig_request,
  output logic      [15:0]         raw_turns,
  output logic                     autoconfig_done,
  output logic      [15:0]         autoconfig_ratio,
  output logic      [7:0]          autoconfig_turns,
  output logic      [`LINES_W-1:0] autoconfig_lines
);
  logic       busy;
  logic [3:0] cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy, cnt, autoconfig_done, raw_turns} <= '0;
      {autoconfig_ratio, autoconfig_turns, autoconfig_lines} <= '0;
    end else begin
      raw_turns <= raw_turns + 16'h0123;
      autoconfig_done <= 1'b0;
      // data not valid outside the answer: inverted so it is never reused
      autoconfig_ratio <= ~autoconfig_ratio;
      autoconfig_turns <= ~autoconfig_turns;
      autoconfig_lines <= ~autoconfig_lines;
      if (autoconfig_request) begin
        busy <= 1'b1;
        cnt <= cfg_delay;
      end else if (busy && cnt != 0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        autoconfig_done <= 1'b1;
        autoconfig_ratio <= cfg_ratio;
        autoconfig_turns <= cfg_turns;
        autoconfig_lines <= cfg_lines;
      end
    end
  end
endmodule // encoder_model

// *** sim/tb_encoder_line_setup.sv ***
/*
 self-checking bench for encoder_line_setup with apb master and ref model.
 assumes 10 MHz pclk and a 2500-cycle background apply period.
*/
`timescale 1ns/10ps
`include "encoder_line_map.vh"
module tb_encoder_line_setup;
  logic pclk, presetn, psel, penable, pwrite, encoder_init, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, c, r, seed, ec[4], ev[4];
  logic [15:0] raw_turns, ac_ratio, cfg_ratio, sine_ratio, tdisp, pr;
  logic [7:0] ac_turns, cfg_turns;
  logic [`LINES_W-1:0] ac_lines, cfg_lines, eq_lines;
  logic [3:0] cfg_delay;
  logic ac_req, ac_done, comm_only, rate_cut, reinit, last_err;
  logic [4:0] res_bits;
  logic [23:0] rev_len;
  integer err_total, num_checks, reinit_n, i, v, n0;
  encoder_line_setup uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .raw_turns(raw_turns), .encoder_init(encoder_init),
    .autoconfig_request(ac_req), .autoconfig_done(ac_done), .autoconfig_ratio(ac_ratio),
    .autoconfig_turns(ac_turns), .autoconfig_lines(ac_lines), .turns_count_display(tdisp),
    .comms_sine_ratio(sine_ratio), .equivalent_lines_per_rev(eq_lines),
    .commutation_only(comm_only), .sample_rate_reduced(rate_cut), .total_res_bits(res_bits),
    .rev_length(rev_len), .encoder_reinit(reinit), .irq(irq));
  encoder_model enc (.pclk(pclk), .presetn(presetn), .cfg_delay(cfg_delay),
    .cfg_ratio(cfg_ratio), .cfg_turns(cfg_turns), .cfg_lines(cfg_lines),
    .autoconfig_request(ac_req), .raw_turns(raw_turns), .autoconfig_done(ac_done),
    .autoconfig_ratio(ac_ratio), .autoconfig_turns(ac_turns), .autoconfig_lines(ac_lines));
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (reinit === 1'b1) reinit_n++;
  function [31:0] xs;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction
  function integer shape(input [31:0] c, input integer v);
    integer p;
    p = 2;
    if (v > 500000) v = 500000;
    if (c[4:3] != 0 && c[11:8] >= 7 && c[11:8] <= 9) begin
      while (p * 2 <= v && p < 32768) p = p * 2;
      shape = p;
    end else if (v == 0 && !(c[11:8] >= 10 || (c[11:8] >= 3 && c[11:8] <= 5 && c[2])))
      shape = 1;
    else shape = v;
  endfunction
  function [15:0] dmask(input [31:0] c, input [15:0] raw, input integer t);
    if (c[4:3] == 0 && c[11:8] >= 7 && c[11:8] <= 11) dmask = raw;
    else dmask = raw & 16'((32'h1 << (t > 16 ? 16 : t)) - 1);
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    last_err = pslverr;
    {psel, penable} <= 2'b00;
    // let what the access edge launched settle before callers look
    @(negedge pclk);
  endtask
  task rdc(input string nm, input [7:0] a, input [31:0] e);
    apb(0, a, 0);
    chk(nm, e, q);
  endtask
  task apply;
    repeat (2600) @(posedge pclk);
    @(negedge pclk);
  endtask
  task init_pulse;
    @(posedge pclk) encoder_init <= 1'b1;
    @(posedge pclk) encoder_init <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
  task turns_chk(input integer t);
    @(negedge pclk) pr = raw_turns;
    @(negedge pclk) chk("turns_disp", dmask(c, pr, t), tdisp);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, encoder_init} = '0;
    {err_total, num_checks, reinit_n} = '0;
    seed = 32'h78c3d4b7;
    {cfg_delay, cfg_ratio, cfg_turns, cfg_lines} = {4'h0, 16'd300, 8'd12, 19'd4096};
    presetn = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", `ADDR_CTRL, 32'h000a0008);
    rdc("turns", `ADDR_TURNS, 32'h10);
    rdc("lines", `ADDR_LINES, 32'h400);
    rdc("poles", `ADDR_POLES, 32'h0606);
    rdc("pitch", `ADDR_PITCH, 32'h20);
    rdc("lines_appl", `ADDR_LINES_APPL, 32'h400);
    rdc("unmapped", 8'h40, 32'h0);
    chk("slverr", 1, last_err);
    // irq: raised by lines write, masked, cleared by status read
    apb(0, `ADDR_IRQ_STATUS, 0);
    apb(1, `ADDR_IRQ_MASK, 1);
    apb(1, `ADDR_LINES, 2048);
    chk("irq", 1, irq);
    rdc("irq_status", `ADDR_IRQ_STATUS, 32'h1);
    chk("irq", 0, irq);
    apb(1, `ADDR_IRQ_MASK, 0);
    apb(1, `ADDR_LINES, 2048);
    chk("irq", 0, irq);
    ec = '{32'h000a0008, 32'h000a0008, 32'h000a0708, 32'h000a0708};
    ev = '{600000, 0, 1, 100000};
    for (i = 0; i < 16; i++) begin
      r = xs();
      c = i < 12 ? (32'h000a0000 | (i << 8) | {r[1], r[0], 2'b00}) : ec[i - 12];
      v = i < 12 ? r[31:12] % 600001 : ev[i - 12];
      apb(1, `ADDR_CTRL, c);
      apb(1, `ADDR_LINES, v);
      rdc("lines", `ADDR_LINES, shape(c, v));
    end
    // linear sine/cosine, 6 kHz switching, non power of two lines
    apb(1, `ADDR_CTRL, 32'h000a2600);
    apb(1, `ADDR_LINES, 1000);
    apply;
    chk("eq_lines", 1000, eq_lines);
    chk("rate_cut", 1, rate_cut);
    chk("res_bits", 19, res_bits);
    apb(1, `ADDR_CTRL, 32'h000a3601);
    apb(1, `ADDR_LINES, 1024);
    apply;
    chk("eq_lines", 1000, eq_lines);
    chk("rate_cut", 0, rate_cut);
    apb(1, `ADDR_CTRL, 32'h000d2600);
    apply;
    chk("eq_lines", 1024, eq_lines);
    chk("res_bits", 21, res_bits);
    // servo incremental with zero lines, then pole and map changes
    apb(1, `ADDR_PITCH, 1000);
    apb(1, `ADDR_CTRL, 32'h000a030c);
    n0 = reinit_n;
    apb(1, `ADDR_LINES, 0);
    apply;
    chk("comm_only", 1, comm_only);
    apb(1, `ADDR_POLES, 32'h0608);
    repeat (4) @(negedge pclk);
    chk("rev_len", 8000, rev_len);
    apb(1, `ADDR_CTRL, 32'h001a030c);
    repeat (4) @(negedge pclk);
    chk("rev_len", 6000, rev_len);
    chk("reinit_n", n0 + 3, reinit_n);
    // linear comms with oversize ratio, slow answer
    cfg_delay = 4'h7;
    c = 32'h000a0802;
    apb(1, `ADDR_CTRL, c);
    repeat (20) @(posedge pclk);
    rdc("turns", `ADDR_TURNS, 255);
    chk("ratio", 300, sine_ratio);
    apb(1, `ADDR_TURNS, 7);
    rdc("turns", `ADDR_TURNS, 255);
    apb(0, `ADDR_STATUS, 0);
    chk("oversize", 1, q[0]);
    cfg_ratio = 100;
    init_pulse;
    rdc("turns", `ADDR_TURNS, 100);
    apb(1, `ADDR_TURNS, 3);
    rdc("turns", `ADDR_TURNS, 3);
    turns_chk(3);
    // serial-only rotary encoder
    cfg_delay = 4'h0;
    c = 32'h000a0a0a;
    apb(1, `ADDR_CTRL, c);
    init_pulse;
    rdc("lines", `ADDR_LINES, 0);
    rdc("turns", `ADDR_TURNS, 12);
    turns_chk(12);
    apb(1, `ADDR_TURNS, 20);
    turns_chk(20);
    tally_and_finish;
  end
endmodule // tb_encoder_line_setup
